// File: ppr_pkg.sv
// Package for the parallel port peripheral register block.
package ppr_pkg;

  localparam logic [11:0] ADDR_NIBBLE_DATA  = 12'h000;
  localparam logic [11:0] ADDR_HOST_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_MIN_DELAY    = 12'h008;
  localparam logic [11:0] ADDR_TO_CMP_LOW   = 12'h00c;
  localparam logic [11:0] ADDR_TO_CMP_HIGH  = 12'h010;
  localparam logic [11:0] ADDR_TO_CNT_LOW   = 12'h014;
  localparam logic [11:0] ADDR_TO_CNT_HIGH  = 12'h018;
  localparam logic [11:0] ADDR_CONTROL      = 12'h01c;
  localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h020;
  localparam logic [11:0] ADDR_IRQ_ENABLE   = 12'h024;
  localparam logic [11:0] ADDR_IRQ_CLEAR    = 12'h028;

  localparam int IEEE_DLY_LSB   = 8;
  localparam int COMPAT_DLY_LSB = 0;
  localparam int DLY_W          = 7;
  localparam int CNT_LOW_W      = 16;
  localparam int CNT_HIGH_W     = 10;
  localparam int TO_W           = 26;

  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_TO_EN_BIT = 4;

  localparam int IRQ_WRREQ_BIT  = 0;
  localparam int IRQ_DONE_BIT   = 1;
  localparam int IRQ_TMO_BIT    = 2;
  localparam int IRQ_W          = 3;

  localparam logic [2:0]  MODE_COMPAT = 3'h0;
  localparam logic [2:0]  MODE_NIBBLE = 3'h1;
  localparam logic [3:0]  HOST_STATUS_RESET = 4'hf;
  localparam logic [15:0] DELAY_RESET = 16'h0000;

  typedef enum logic [2:0] {
    NB_IDLE    = 3'b000,
    NB_REQ     = 3'b001,
    NB_SEND_HI = 3'b010,
    NB_SEND_LO = 3'b011,
    NB_ACK     = 3'b100
  } ppr_nib_state_t;

endpackage

// File: ppr_delay.sv
// Minimum interface delay timer; counts the programmed number of clocks.
`timescale 1ns/100ps
module ppr_delay
  import ppr_pkg::*;
#(
  parameter int W = 7
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
    logic         done;
  } ppr_dly_t;

  ppr_dly_t q;
  ppr_dly_t next_q;

  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    if (start_i) begin
      next_q.cnt = count_i;
      next_q.run = 1'b1;
    end else if (q.run) begin
      // A count of zero is undefined; it behaves as one clock here.
      if (q.cnt <= W'(1)) begin
        next_q.run  = 1'b0;
        next_q.done = 1'b1;
      end else begin
        next_q.cnt = q.cnt - W'(1);
      end
    end
  end

  always_ff @(negedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done_o = q.done;

endmodule // ppr_delay

// File: ppr_timeout.sv
// Twenty-six bit host time-out counter with compare and diagnostic load.
`timescale 1ns/100ps
module ppr_timeout
  import ppr_pkg::*;
#(
  parameter int W = 26
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         enable_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] compare_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  output logic [W-1:0]      count_o,
  output logic              timeout_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tmo;
  } ppr_to_t;

  ppr_to_t q;
  ppr_to_t next_q;

  always_comb begin
    next_q     = q;
    next_q.tmo = 1'b0;
    if (start_i) begin
      next_q.cnt = '0;
    end else if (load_i) begin
      next_q.cnt = load_val_i;
    end else if (enable_i) begin
      if (q.cnt == compare_i) begin
        next_q.tmo = 1'b1;
      end else begin
        next_q.cnt = q.cnt + W'(1);
      end
    end
  end

  always_ff @(negedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign count_o   = q.cnt;
  assign timeout_o = q.tmo;

endmodule // ppr_timeout

// File: ppr_regs.sv
// Parallel port peripheral registers, nibble reverse transfer and host time-out.
// Notes on behaviour
// - Nibble data writes refused before write-request seen.
// - Send upper then lower nibble on four lines.
// - Status bit 0 mirrors nStrobe.
// - Status bit 1 mirrors nSelectIn.
// - Status bit 2 mirrors nInit.
// - Status bit 3 mirrors nAutoFd.
// - IEEE delay count from bits 14:8.
// - Compatibility delay count from bits 6:0.
// - Delay field is clocks; zero undefined.
// - Time-out when counter equals joined compare.
// - Counter accessible only while enabled; diagnostic.
// - Port signals driven and sampled on falling edge.
// - Nibble mode when mode field is 001.
`timescale 1ns/100ps
module ppr_regs
  import ppr_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_n_strobe_i,
  input  wire logic        host_n_select_in_i,
  input  wire logic        host_n_init_i,
  input  wire logic        host_n_auto_fd_i,
  output logic [3:0]       nibble_lines_o,
  output logic             nibble_valid_o,
  output logic             ieee_handshake_ok_o,
  output logic             compat_handshake_ok_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [3:0]          host_sync;
    logic [7:0]          nib_data;
    logic                nib_armed;
    logic                nib_loaded;
    ppr_nib_state_t      nib_st;
    logic [3:0]          nib_lines;
    logic                nib_valid;
    logic [15:0]         delay;
    logic [CNT_LOW_W-1:0]  cmp_lo;
    logic [CNT_HIGH_W-1:0] cmp_hi;
    logic [2:0]          mode;
    logic                to_en;
    logic                strobe_d;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_en;
    logic [31:0]         rdata;
  } ppr_regs_t;

  ppr_regs_t q;
  ppr_regs_t next_q;

  logic            wr_acc;
  logic            rd_acc;
  logic            addr_ok;
  logic            dly_start;
  logic            ieee_done;
  logic            compat_done;
  logic            to_start;
  logic            to_load;
  logic [TO_W-1:0] to_load_val;
  logic [TO_W-1:0] to_count;
  logic            to_fire;
  logic            strobe_fall;

  function automatic logic known_addr(input logic [11:0] a);
    unique case (a)
      ADDR_NIBBLE_DATA, ADDR_HOST_STATUS, ADDR_MIN_DELAY, ADDR_TO_CMP_LOW,
      ADDR_TO_CMP_HIGH, ADDR_TO_CNT_LOW, ADDR_TO_CNT_HIGH, ADDR_CONTROL,
      ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB access decode.

  assign addr_ok = known_addr(paddr);
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = q.rdata;

  // Host strobe falling edge marks the host acknowledging a nibble.
  assign strobe_fall = q.strobe_d && !q.host_sync[0];

  // Diagnostic counter writes land only while the counter is enabled.
  assign to_load     = wr_acc && q.to_en && (paddr == ADDR_TO_CNT_LOW || paddr == ADDR_TO_CNT_HIGH);
  assign to_load_val = (paddr == ADDR_TO_CNT_LOW) ? {to_count[TO_W-1:CNT_LOW_W], pwdata[CNT_LOW_W-1:0]}
                                                  : {pwdata[CNT_HIGH_W-1:0], to_count[CNT_LOW_W-1:0]};
  assign to_start    = (q.nib_st == NB_SEND_HI) && (q.nib_st != next_q.nib_st) ||
                       (q.nib_st == NB_IDLE && next_q.nib_st == NB_REQ);
  assign dly_start   = (q.nib_st != next_q.nib_st) && (next_q.nib_st == NB_SEND_HI ||
                       next_q.nib_st == NB_SEND_LO);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    next_q = q;
    // Host lines are sampled on the falling edge via the register process.
    next_q.host_sync = {host_n_auto_fd_i, host_n_init_i, host_n_select_in_i, host_n_strobe_i};
    next_q.strobe_d  = q.host_sync[0];
    next_q.rdata     = 32'h0000_0000;

    if (wr_acc) begin
      unique case (paddr)
        ADDR_NIBBLE_DATA: begin
          if (q.nib_armed) begin
            next_q.nib_data   = pwdata[7:0];
            next_q.nib_loaded = 1'b1;
          end
        end
        ADDR_MIN_DELAY: begin
          // Reserved bits 15 and 7 are kept at zero whatever is written.
          next_q.delay = {1'b0, pwdata[14:8], 1'b0, pwdata[6:0]};
        end
        ADDR_TO_CMP_LOW:  next_q.cmp_lo = pwdata[CNT_LOW_W-1:0];
        ADDR_TO_CMP_HIGH: next_q.cmp_hi = pwdata[CNT_HIGH_W-1:0];
        ADDR_CONTROL: begin
          next_q.mode  = pwdata[CTRL_MODE_LSB +: 3];
          next_q.to_en = pwdata[CTRL_TO_EN_BIT];
        end
        ADDR_IRQ_ENABLE: next_q.irq_en = pwdata[IRQ_W-1:0];
        ADDR_IRQ_CLEAR:  next_q.irq_stat = q.irq_stat & ~pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    if (rd_acc) begin
      unique case (paddr)
        ADDR_NIBBLE_DATA: next_q.rdata = {24'h00_0000, q.nib_data};
        ADDR_HOST_STATUS: next_q.rdata = {28'h000_0000, q.host_sync};
        ADDR_MIN_DELAY:   next_q.rdata = {16'h0000, q.delay};
        ADDR_TO_CMP_LOW:  next_q.rdata = {16'h0000, q.cmp_lo};
        ADDR_TO_CMP_HIGH: next_q.rdata = {22'h00_0000, q.cmp_hi};
        ADDR_TO_CNT_LOW:  next_q.rdata = q.to_en ? {16'h0000, to_count[CNT_LOW_W-1:0]} : 32'h0000_0000;
        ADDR_TO_CNT_HIGH: next_q.rdata = q.to_en ? {22'h00_0000, to_count[TO_W-1:CNT_LOW_W]} : 32'h0000_0000;
        ADDR_CONTROL:     next_q.rdata = {27'h000_0000, q.to_en, 1'b0, q.mode};
        ADDR_IRQ_STATUS:  next_q.rdata = {29'h0000_0000, q.irq_stat};
        ADDR_IRQ_ENABLE:  next_q.rdata = {29'h0000_0000, q.irq_en};
        default:          next_q.rdata = 32'h0000_0000;
      endcase
    end

    // Nibble reverse transfer sequencer.
    unique case (q.nib_st)
      NB_IDLE: begin
        next_q.nib_valid = 1'b0;
        if (q.mode == MODE_NIBBLE) begin
          next_q.nib_st               = NB_REQ;
          next_q.nib_armed            = 1'b1;
          next_q.irq_stat[IRQ_WRREQ_BIT] = 1'b1;
        end
      end
      NB_REQ: begin
        if (q.mode != MODE_NIBBLE) begin
          next_q.nib_st    = NB_IDLE;
          next_q.nib_armed = 1'b0;
        end else if (next_q.nib_loaded) begin
          next_q.nib_st     = NB_SEND_HI;
          next_q.nib_armed  = 1'b0;
          next_q.nib_lines  = next_q.nib_data[7:4];
        end
      end
      NB_SEND_HI: begin
        if (ieee_done) begin
          next_q.nib_valid = 1'b1;
        end
        if (q.nib_valid && strobe_fall) begin
          next_q.nib_st    = NB_SEND_LO;
          next_q.nib_valid = 1'b0;
          next_q.nib_lines = q.nib_data[3:0];
        end
      end
      NB_SEND_LO: begin
        if (ieee_done) begin
          next_q.nib_valid = 1'b1;
        end
        if (q.nib_valid && strobe_fall) begin
          next_q.nib_st    = NB_ACK;
          next_q.nib_valid = 1'b0;
        end
      end
      NB_ACK: begin
        next_q.nib_loaded          = 1'b0;
        next_q.nib_st              = NB_IDLE;
        next_q.irq_stat[IRQ_DONE_BIT] = 1'b1;
      end
      default: next_q.nib_st = NB_IDLE;
    endcase

    // A time-out abandons the transfer; event sets win over software clears.
    if (to_fire) begin
      next_q.irq_stat[IRQ_TMO_BIT] = 1'b1;
      next_q.nib_st    = NB_IDLE;
      next_q.nib_valid = 1'b0;
      next_q.nib_armed = 1'b0;
      next_q.nib_loaded = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; all port-facing state moves on the falling edge.

  always_ff @(negedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q           <= '0;
      q.host_sync <= HOST_STATUS_RESET;
      q.strobe_d  <= 1'b1;
      q.delay     <= DELAY_RESET;
      q.mode      <= MODE_COMPAT;
      q.nib_st    <= NB_IDLE;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay timers and host time-out.

  ppr_delay #(.W(DLY_W)) u_ieee_dly (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .start_i   (dly_start),
    .count_i   (q.delay[IEEE_DLY_LSB +: DLY_W]),
    .done_o    (ieee_done)
  );

  ppr_delay #(.W(DLY_W)) u_compat_dly (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .start_i   (strobe_fall && q.mode == MODE_COMPAT),
    .count_i   (q.delay[COMPAT_DLY_LSB +: DLY_W]),
    .done_o    (compat_done)
  );

  ppr_timeout #(.W(TO_W)) u_timeout (
    .sys_clk_i  (sys_clk_i),
    .rstn_i     (rstn_i),
    .enable_i   (q.to_en && q.nib_st != NB_IDLE),
    .start_i    (to_start),
    .compare_i  ({q.cmp_hi, q.cmp_lo}),
    .load_i     (to_load),
    .load_val_i (to_load_val),
    .count_o    (to_count),
    .timeout_o  (to_fire)
  );

  assign nibble_lines_o        = q.nib_lines;
  assign nibble_valid_o        = q.nib_valid;
  assign ieee_handshake_ok_o   = ieee_done;
  assign compat_handshake_ok_o = compat_done;
  assign irq_o                 = |(q.irq_stat & q.irq_en);

endmodule // ppr_regs

// File: ppr_sva.sv
// Assertion checker for the parallel port register block.
`timescale 1ns/100ps
module ppr_sva
  import ppr_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        host_n_strobe_i,
  input wire logic        host_n_select_in_i,
  input wire logic        host_n_init_i,
  input wire logic        host_n_auto_fd_i,
  input wire logic [3:0]  nibble_lines_o,
  input wire logic        nibble_valid_o,
  input wire logic        ieee_handshake_ok_o,
  input wire logic        compat_handshake_ok_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic       rd     = psel && penable && !pwrite;
  wire logic [3:0] hl     = {host_n_auto_fd_i, host_n_init_i, host_n_select_in_i, host_n_strobe_i};
  wire logic       mapped = paddr[1:0] == 2'b00 && paddr <= ADDR_IRQ_CLEAR;
  sequence lines_held;
    $stable(hl) [*3];
  endsequence
  sequence strobe_taken;
    nibble_valid_o && $fell(host_n_strobe_i);
  endsequence
  status_mirror_a: assert property (lines_held ##0 rd && paddr == ADDR_HOST_STATUS |->
    prdata == {28'h000_0000, hl}) else $error("host status mismatch");
  nibble_upper_a: assert property (rd && paddr == ADDR_NIBBLE_DATA |-> prdata[31:8] == 24'h00_0000)
    else $error("nibble data upper bits set");
  delay_fields_a: assert property (rd && paddr == ADDR_MIN_DELAY |->
    !prdata[15] && !prdata[7] && prdata[31:16] == 16'h0000) else $error("delay reserved bits set");
  strobe_drop_a: assert property (strobe_taken |-> ##[1:3] !nibble_valid_o)
    else $error("nibble valid held after strobe");
  lines_hold_a: assert property (nibble_valid_o && host_n_strobe_i ##1 host_n_strobe_i |->
    $stable(nibble_lines_o)) else $error("nibble lines moved");
  ieee_pulse_a: assert property (ieee_handshake_ok_o |=> !ieee_handshake_ok_o)
    else $error("ieee pulse too long");
  compat_pulse_a: assert property (compat_handshake_ok_o |=> !compat_handshake_ok_o)
    else $error("compat pulse too long");
  unmapped_error_a: assert property (psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
endmodule // ppr_sva
bind ppr_regs ppr_sva u_sva (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .host_n_strobe_i(host_n_strobe_i),
  .host_n_select_in_i(host_n_select_in_i), .host_n_init_i(host_n_init_i), .host_n_auto_fd_i(host_n_auto_fd_i),
  .nibble_lines_o(nibble_lines_o), .nibble_valid_o(nibble_valid_o), .ieee_handshake_ok_o(ieee_handshake_ok_o),
  .compat_handshake_ok_o(compat_handshake_ok_o));

// File: ppr_host_model.sv
// Host side model that strobes nibbles out of the block and reports each byte.
`timescale 1ns/100ps
module ppr_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] nibble_lines_i,
  input  wire logic       nibble_valid_i,
  input  wire logic [1:0] slow_i,
  output logic            host_n_strobe_o,
  output logic [7:0]      byte_o,
  output logic            byte_stb_o
);
  logic half = 1'b0;
  initial begin
    host_n_strobe_o = 1'b1;
    byte_o = 8'h00;
    byte_stb_o = 1'b0;
    forever begin
      @(posedge sys_clk_i);
      byte_stb_o <= 1'b0;
      if (rstn_i && nibble_valid_i === 1'b1) begin
        repeat (slow_i) @(posedge sys_clk_i);
        // Upper nibble arrives first, so it fills bits 7:4.
        if (!half) byte_o[7:4] <= nibble_lines_i;
        else byte_o[3:0] <= nibble_lines_i;
        host_n_strobe_o <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        host_n_strobe_o <= 1'b1;
        byte_stb_o <= half;
        half = !half;
      end
    end
  end
endmodule // ppr_host_model

// File: parallel_port_peripheral_regs_tb.sv
// Self-checking testbench for the parallel port register block.
`timescale 1ns/100ps
module parallel_port_peripheral_regs_tb
  import ppr_pkg::*;
;
  typedef struct packed { logic e; logic [31:0] m; logic [31:0] d; } ppr_exp_t;
  logic        sys_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [2:0]  hl        = 3'h7;
  logic        tb_strb   = 1'b1;
  logic [1:0]  slow      = 2'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, strb_m, valid, ieee_ok, compat_ok, irq, bstb;
  logic [3:0]  lines;
  logic [7:0]  hbyte, b;
  logic [6:0]  ie, co;
  ppr_exp_t    exp_q[$];
  logic [7:0]  byte_q[$];
  ppr_exp_t    ex;
  int          bad_count = 0, n_checks = 0, cyc = 0, k;
  wire logic   strb = strb_m & tb_strb;
  initial forever #5 sys_clk_i = ~sys_clk_i;
  ppr_regs dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_n_strobe_i(strb), .host_n_select_in_i(hl[0]), .host_n_init_i(hl[1]), .host_n_auto_fd_i(hl[2]),
    .nibble_lines_o(lines), .nibble_valid_o(valid), .ieee_handshake_ok_o(ieee_ok),
    .compat_handshake_ok_o(compat_ok), .irq_o(irq));
  ppr_host_model u_host (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .nibble_lines_i(lines), .nibble_valid_i(valid),
    .slow_i(slow), .host_n_strobe_o(strb_m), .byte_o(hbyte), .byte_stb_o(bstb));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // The expectation is queued first; the watcher pops it at the access edge.
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m = 32'hffff_ffff,
                    input logic e = 1'b0);
    exp_q.push_back('{e, m, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic lat(input logic sel, input int d);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while ((sel ? valid : compat_ok) !== 1'b1 && n < d + 8);
    chk(n >= d && n <= d + 4, "handshake delay out of range");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite) begin
      ex = exp_q.pop_front();
      chk({pslverr, prdata & ex.m} === {ex.e, ex.d & ex.m}, "read data");
    end
    if (bstb === 1'b1) chk(hbyte === byte_q.pop_front(), "nibble byte");
    // Whole run is a few hundred cycles; this only catches a hang.
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    k = $urandom(32'hd40f29d5);
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rd(ADDR_HOST_STATUS, 32'h0000_000f);
    for (int i = 0; i < 16; i++) begin
      {hl, tb_strb} <= i[3:0];
      repeat (3) @(posedge sys_clk_i);
      rd(ADDR_HOST_STATUS, {28'h000_0000, i[3:0]});
    end
    wr(ADDR_NIBBLE_DATA, 32'h0000_00a5);
    repeat (12) @(posedge sys_clk_i);
    chk(valid === 1'b0 && lines === 4'h0, "refused nibble write sent");
    for (int j = 0; j < 2; j++) begin
      ie = 7'($urandom_range(12, 1));
      co = 7'($urandom_range(20, 1));
      wr(ADDR_MIN_DELAY, {16'h0000, 1'b0, ie, 1'b0, co});
      rd(ADDR_MIN_DELAY, {16'h0000, 1'b0, ie, 1'b0, co});
      tb_strb <= 1'b0;
      lat(1'b0, int'(co));
      tb_strb <= 1'b1;
    end
    wr(ADDR_IRQ_ENABLE, 32'h0000_0007);
    wr(ADDR_CONTROL, {29'h0000_0000, MODE_NIBBLE});
    rd(ADDR_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
    chk(irq === 1'b1, "write request irq low");
    for (int j = 0; j < 3; j++) begin
      ie = 7'($urandom_range(12, 1));
      wr(ADDR_MIN_DELAY, {16'h0000, 1'b0, ie, 8'h05});
      b = 8'($urandom);
      slow <= 2'($urandom);
      byte_q.push_back(b);
      wr(ADDR_NIBBLE_DATA, {24'h00_0000, b});
      lat(1'b1, int'(ie));
      k = 0;
      while (byte_q.size() != 0 && k++ < 400) @(posedge sys_clk_i);
      repeat (4) @(posedge sys_clk_i);
    end
    rd(ADDR_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002);
    wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge sys_clk_i);
    chk(irq === 1'b0, "masked irq high");
    wr(ADDR_IRQ_CLEAR, 32'h0000_0002);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000, 32'h0000_0002);
    rd(ADDR_IRQ_CLEAR, 32'h0000_0000);
    rd(12'h030, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    rd(ADDR_TO_CNT_LOW, 32'h0000_0000);
    // A diagnostic preload 20 clocks short of the compare keeps the run brief; real software aims at about one second.
    wr(ADDR_TO_CMP_LOW, 32'h0000_0028);
    wr(ADDR_TO_CMP_HIGH, 32'h0000_0001);
    wr(ADDR_CONTROL, 32'h0000_0011);
    repeat (60) @(posedge sys_clk_i);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000, 32'h0000_0004);
    wr(ADDR_TO_CNT_HIGH, 32'h0000_0001);
    wr(ADDR_TO_CNT_LOW, 32'h0000_0014);
    repeat (40) @(posedge sys_clk_i);
    rd(ADDR_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004);
    wr(ADDR_IRQ_ENABLE, 32'h0000_0004);
    repeat (2) @(posedge sys_clk_i);
    chk(irq === 1'b1, "time-out irq low");
    give_verdict();
  end
endmodule // parallel_port_peripheral_regs_tb
